// [bench/hfp_host_model.sv]
`timescale 1ns/10ps
// host processor side of the register bus
module hfp_host_model (
    input  wire logic        clk_in,
    output logic      [7:0]  addr_out,
    output logic      [31:0] wdata_out,
    output logic             wr_out,
    output logic             rd_out,
    input  wire logic [31:0] rdata_in
);
    initial {addr_out, wdata_out, wr_out, rd_out} = '0;
    // one-cycle write, used after a first read except once right after the soft reset
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
    endtask
    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        #1 d = rdata_in;
    endtask
endmodule

// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
    import hfp_pkg::*;
    logic clk_sys_in = 0, reset_in = 1, phy_clks_running_in = 1, mac_rx_valid_in = 0;
    logic mac_rx_last_in = 0, host_tx_wr_in = 0, host_tx_last_in = 0, host_rx_rd_in = 0;
    logic mac_tx_rd_in = 0, reg_wr_in, reg_rd_in, host_tx_full_out, host_rx_last_out;
    logic host_rx_valid_out, mac_tx_last_out, mac_tx_valid_out, mac_tx_avail_out;
    logic mac_csr_reset_out;
    logic [31:0] mac_rx_data_in = 0, host_tx_data_in = 0, reg_wdata_in, reg_rdata_out;
    logic [31:0] host_rx_data_out, mac_tx_data_out, d, w;
    logic [7:0]  reg_addr_in;
    logic [15:0] r = 16'h0018;
    wire  [31:0] flags = {28'h0, mac_tx_valid_out, mac_tx_last_out,
                          host_rx_valid_out, host_rx_last_out};
    int          n_mismatch = 0, compares = 0;
    hfp_top uut (.*);
    hfp_host_model host (.clk_in(clk_sys_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in),
        .wr_out(reg_wr_in), .rd_out(reg_rd_in), .rdata_in(reg_rdata_out));
    always #10 clk_sys_in = ~clk_sys_in;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // expected capacities in words: data queues, or status queues when st is set
    function automatic logic [31:0] cap(input int s, input bit st);
        int t, x;
        t = s * 256;
        x = 4096 - t;
        cap = st ? {16'h0, 8'(x / 16), 8'h80} : {3'h0, 13'(x - x / 16), 3'h0, 13'(t - 128)};
    endfunction
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    initial begin
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        host.rd(HWCFG_OFS, d);
        chk("hwcfg", 32'h0005_0000, d);
        for (int s = 2; s <= 14; s++) begin
            host.wr(HWCFG_OFS, 32'(s) << TXSZ_LSB);
            host.rd(QSIZE_OFS, d);
            chk("qsize", cap(s, 0), d);
            host.rd(SSIZE_OFS, d);
            chk("ssize", cap(s, 1), d);
        end
        $display("partition test done");
        // size 14: rx queue stops at its mark, staging fills, later frames drop
        repeat (520) begin
            @(posedge clk_sys_in);
            r = lfsr(r);
            mac_rx_valid_in <= 1;
            mac_rx_last_in <= 1;
            mac_rx_data_in <= {r, ~r};
        end
        @(posedge clk_sys_in);
        mac_rx_valid_in <= 0;
        host.rd(DROP_OFS, d);
        chk("drop", 32'h0000_000c, d);
        host.rd(QSTAT_OFS, d);
        chk("qstat", 32'h0000_01dc, d);
        host.wr(RXDP_OFS, 32'h8000_0000);
        host.rd(RXDP_OFS, d);
        chk("skip", 32'h0, d);
        // size 2: 384 words queued, two frames staged, the last push refused
        host.wr(HWCFG_OFS, 32'h0002_0000);
        repeat (387) begin
            @(posedge clk_sys_in);
            host_tx_wr_in <= 1;
            host_tx_last_in <= 1;
        end
        @(posedge clk_sys_in);
        host_tx_wr_in <= 0;
        #1 chk("txfull", 32'h1, 32'(host_tx_full_out));
        host.rd(QSTAT_OFS, d);
        chk("qstat", 32'h4000_0000, d);
        $display("queue limit test done");
        host.wr(HWCFG_OFS, 32'h0016_0000);
        r = lfsr(r);
        w = {r, lfsr(r)};
        host_tx_wr_in <= 1;
        host_tx_data_in <= w;
        host_tx_last_in <= 1;
        mac_rx_valid_in <= 1;
        mac_rx_data_in <= ~w;
        mac_rx_last_in <= 1;
        @(posedge clk_sys_in);
        {host_tx_wr_in, mac_rx_valid_in} <= 2'h0;
        repeat (4) @(posedge clk_sys_in);
        {mac_tx_rd_in, host_rx_rd_in} <= 2'h3;
        #1 chk("avail", 32'h1, 32'(mac_tx_avail_out));
        @(posedge clk_sys_in);
        {mac_tx_rd_in, host_rx_rd_in} <= 2'h1;
        #1 chk("txdata", w, mac_tx_data_out);
        chk("rxdata", ~w, host_rx_data_out);
        chk("flags", 32'hf, flags);
        @(posedge clk_sys_in);
        {host_rx_rd_in, phy_clks_running_in} <= 2'h0;
        host.rd(QSTAT_OFS, d);
        chk("qstat", 32'hc000_0000, d);
        $display("data test done");
        host.wr(HWCFG_OFS, 32'h1);
        repeat (3) @(posedge clk_sys_in);
        host.rd(HWCFG_OFS, d);
        chk("timeout", 32'h0016_0002, d);
        @(posedge clk_sys_in);
        phy_clks_running_in <= 1;
        host.wr(HWCFG_OFS, 32'h1);
        @(posedge clk_sys_in);
        #1 chk("csr_rst", 32'h1, 32'(mac_csr_reset_out));
        repeat (5) @(posedge clk_sys_in);
        #1 chk("csr_rst", 32'h0, 32'(mac_csr_reset_out));
        host.wr(HWCFG_OFS, 32'h0007_0000);
        host.rd(HWCFG_OFS, d);
        chk("hwcfg", 32'h0015_0000, d);
        host.rd(QSTAT_OFS, d);
        chk("qstat", 32'h0, d);
        host.rd(DROP_OFS, d);
        chk("drop", 32'h0, d);
        $display("reset test done");
        report_and_stop();
    end
    initial begin
        repeat (5000) @(posedge clk_sys_in);
        n_mismatch++;
        report_and_stop();
    end
endmodule

// [hdl/hfp_top.sv]
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// staging fifo, word plus end-of-frame flag, head read combinationally
module hfp_stage_fifo #(
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic          clk_sys_in,
    input  wire logic          reset_in,
    input  wire logic          flush_in,
    input  wire logic          push_in,
    input  wire logic [32:0]   push_data_in,
    input  wire logic          pop_in,
    output logic      [32:0]   head_out,
    output logic      [AW:0]   count_out,
    output logic               full_out,
    output logic               empty_out
);
    logic [32:0]   mem [DEPTH];   // storage
    logic [AW-1:0] wr_ff;         // write index
    logic [AW-1:0] rd_ff;         // read index
    logic [AW:0]   cnt_ff;        // occupancy
    wire           do_push = push_in & ~full_out;
    wire           do_pop  = pop_in & ~empty_out;

    assign head_out  = mem[rd_ff];
    assign count_out = cnt_ff;
    assign full_out  = (cnt_ff == (AW+1)'(DEPTH));
    assign empty_out = (cnt_ff == '0);

    // storage write, no reset needed
    always_ff @(posedge clk_sys_in) begin
        if (do_push) begin
            mem[wr_ff] <= push_data_in;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || flush_in) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff  <= do_push ? wr_ff + 1'b1 : wr_ff;
            rd_ff  <= do_pop ? rd_ff + 1'b1 : rd_ff;
            cnt_ff <= cnt_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RQ1 - reset without phy clocks aborts, sets timeout
// RQ2 - host fixes phy then retries reset
// RQ3 - reset clears mac control and status registers
// RQ4 - reset clears system registers except exempt bits
// RQ5 - reset clears latched transmit and receive errors
// RQ6 - reset request bit clears itself when done
// RQ7 - host requests reset only with phy clocks
// RQ8 - writes ignored until first read after reset
// RQ9 - transmit status queue fixed 128 words
// RQ10 - transmit data queue gets rest of allocation
// RQ11 - receive allocation is 16384 bytes minus transmit
// RQ12 - receive status is one sixteenth of receive
// RQ13 - host programs size only 2 through 14
// RQ14 - receive data full four words early
// RQ15 - fixed 2K transmit, 128 byte receive staging
// RQ16 - transmit staging refills, holds two frames max
// RQ17 - receive data stages then moves to queue
// RQ18 - overrun drops frames, counts each lost frame; code counts only frames dropped from their first word
// RQ19 - staging levels hidden from reported levels
// RQ20 - skip bit discards to next frame start
// RQ21 - host reads no receive data during skip
// RQ22 - size field counts transmit allocation in KB
// RQ23 - queue sizes count 32-bit words
module hfp_top
    import hfp_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic      [31:0] reg_rdata_out,
    input  wire logic        phy_clks_running_in,
    input  wire logic        mac_rx_valid_in,
    input  wire logic [31:0] mac_rx_data_in,
    input  wire logic        mac_rx_last_in,
    input  wire logic        host_tx_wr_in,
    input  wire logic [31:0] host_tx_data_in,
    input  wire logic        host_tx_last_in,
    output logic             host_tx_full_out,
    input  wire logic        host_rx_rd_in,
    output logic      [31:0] host_rx_data_out,
    output logic             host_rx_last_out,
    output logic             host_rx_valid_out,
    input  wire logic        mac_tx_rd_in,
    output logic      [31:0] mac_tx_data_out,
    output logic             mac_tx_last_out,
    output logic             mac_tx_valid_out,
    output logic             mac_tx_avail_out,
    output logic             mac_csr_reset_out
);
    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [32:0]   shared_mem [4096];  // shared packet buffer, word + last flag
    hfp_sr_state_t sr_state_ff;        // soft reset sequencer
    logic [2:0]    sr_cnt_ff;          // soft reset duration
    logic          sr_to_ff;           // reset_timeout_flag
    logic [3:0]    txsz_ff;            // transmit_allocation_size
    logic          exempt_ff;          // reset_exempt_bit
    logic          skip_ff;            // receive_skip_frame
    logic          txe_ff;             // transmit_error_flag
    logic          rxe_ff;             // receive_error_flag
    logic          read_seen_ff;       // first read after reset seen
    logic [31:0]   drop_ff;            // dropped frame counter
    logic [11:0]   txq_wr_ff;          // tx data queue write offset
    logic [11:0]   txq_rd_ff;          // tx data queue read offset
    logic [12:0]   txq_cnt_ff;         // tx data queue words used
    logic [11:0]   rxq_wr_ff;          // rx data queue write offset
    logic [11:0]   rxq_rd_ff;          // rx data queue read offset
    logic [12:0]   rxq_cnt_ff;         // rx data queue words used
    logic [1:0]    tstg_frames_ff;     // frame ends held in tx staging
    logic          rx_mid_ff;          // mac rx word stream is mid-frame
    logic          rx_lost_ff;         // current mac rx frame is being dropped
    logic          discard_ff;         // overrun seen, dropping until room

    ////////////////////////////////////////////////////////////////////////////
    // partition arithmetic
    wire [12:0] tx_total = {1'b0, txsz_ff, 8'h00};            // RQ22 RQ23
    wire [12:0] txd_cap  = tx_total - TXS_WORDS;             // RQ9 RQ10
    wire [12:0] rx_total = BUF_WORDS - tx_total;             // RQ11
    wire [12:0] rxs_cap  = rx_total >> RXS_SHIFT;            // RQ12
    wire [12:0] rxd_cap  = rx_total - rxs_cap;               // RQ12
    wire [12:0] rxd_lim  = rxd_cap - RXD_MARGIN;             // RQ14
    wire [11:0] rx_base  = tx_total[11:0];

    ////////////////////////////////////////////////////////////////////////////
    // register decode
    wire        wr_ok     = reg_wr_in & read_seen_ff;        // RQ8
    wire        sel_hwcfg = (reg_addr_in == HWCFG_OFS);
    wire        sel_rxdp  = (reg_addr_in == RXDP_OFS);
    wire        sel_drop  = (reg_addr_in == DROP_OFS);
    wire        sel_qstat = (reg_addr_in == QSTAT_OFS);
    wire        sel_qsize = (reg_addr_in == QSIZE_OFS);
    wire        sel_ssize = (reg_addr_in == SSIZE_OFS);
    wire        wr_hwcfg  = wr_ok & sel_hwcfg;
    wire        sr_busy   = (sr_state_ff == SR_BUSY);
    wire        sr_req    = wr_hwcfg & reg_wdata_in[SOFTWARE_RESET_REQUEST_BIT] & ~sr_busy;
    wire        sr_abort  = sr_busy & ~phy_clks_running_in;  // RQ1
    wire        sr_done   = sr_busy & phy_clks_running_in & (sr_cnt_ff == '0);
    wire        size_wr   = wr_hwcfg & ~reg_wdata_in[SOFTWARE_RESET_REQUEST_BIT];
    wire        flush     = sr_done | size_wr;               // queues restart empty
    wire [31:0] hwcfg_rd  = {11'h0, exempt_ff, txsz_ff, 14'h0, sr_to_ff, sr_busy};
    wire [31:0] qstat_rd  = {rxe_ff, txe_ff, 17'h0, rxq_cnt_ff};   // RQ19
    wire [31:0] qsize_rd  = {3'h0, rxd_cap, 3'h0, txd_cap};
    wire [31:0] ssize_rd  = {16'h0, rxs_cap[7:0], TXS_WORDS[7:0]};
    wire [31:0] rd_mux    = sel_hwcfg ? hwcfg_rd :
                            sel_rxdp  ? {skip_ff, 31'h0} :
                            sel_drop  ? drop_ff :
                            sel_qstat ? qstat_rd :
                            sel_qsize ? qsize_rd :
                            sel_ssize ? ssize_rd : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // transmit path
    logic [32:0] tstg_head;            // tx staging head word
    logic [9:0]  tstg_cnt;             // tx staging occupancy
    logic        tstg_full;            // tx staging full
    logic        tstg_empty;           // tx staging empty
    wire         txq_full  = (txq_cnt_ff >= txd_cap);
    wire         txq_empty = (txq_cnt_ff == '0);
    wire         txq_push  = host_tx_wr_in & ~txq_full & ~flush;
    wire [32:0]  txq_head  = shared_mem[txq_rd_ff];
    wire         tx_move   = ~txq_empty & ~tstg_full & ~flush
                           & (tstg_frames_ff < TX_STG_FRAMES);       // RQ16
    wire         tx_out    = mac_tx_rd_in & ~tstg_empty & ~flush;
    wire         txe_set   = host_tx_wr_in & txq_full;
    wire [11:0]  txq_wr_n  = (13'(txq_wr_ff) == txd_cap - 13'h1) ? '0 : txq_wr_ff + 12'h1;
    wire [11:0]  txq_rd_n  = (13'(txq_rd_ff) == txd_cap - 13'h1) ? '0 : txq_rd_ff + 12'h1;

    // fixed 2K byte transmit staging buffer
    hfp_stage_fifo #(.DEPTH(TX_STG_WORDS), .AW(TX_STG_AW)) u_tx_stage (    // RQ15
        .clk_sys_in   (clk_sys_in),
        .reset_in     (reset_in),
        .flush_in     (flush),
        .push_in      (tx_move),
        .push_data_in (txq_head),
        .pop_in       (tx_out),
        .head_out     (tstg_head),
        .count_out    (tstg_cnt),
        .full_out     (tstg_full),
        .empty_out    (tstg_empty)
    );

    ////////////////////////////////////////////////////////////////////////////
    // receive path
    logic [32:0] rstg_head;            // rx staging head word
    logic        rstg_full;            // rx staging full
    logic        rstg_empty;           // rx staging empty
    wire         rxq_room  = (rxq_cnt_ff < rxd_lim);                  // RQ14
    wire         rxq_empty = (rxq_cnt_ff == '0);
    wire         frm_start = mac_rx_valid_in & ~rx_mid_ff;
    wire         drop_now  = rx_lost_ff | rstg_full | (discard_ff & ~rxq_room);
    wire         rstg_push = mac_rx_valid_in & ~drop_now & ~flush;   // RQ17
    wire         rx_drain  = ~rstg_empty & rxq_room & ~flush;         // RQ17
    wire         skip_pop  = skip_ff & ~rxq_empty & ~flush;           // RQ20
    wire         host_pop  = host_rx_rd_in & ~skip_ff & ~rxq_empty & ~flush;
    wire         rxq_pop   = skip_pop | host_pop;
    wire [32:0]  rxq_head  = shared_mem[12'(rx_base + rxq_rd_ff)];
    wire         skip_end  = skip_pop & rxq_head[32];                 // RQ20
    wire         rxe_set   = host_rx_rd_in & ~skip_ff & rxq_empty;
    wire         drop_inc  = frm_start & drop_now & ~flush;           // RQ18
    wire [11:0]  rxq_wr_n  = (13'(rxq_wr_ff) == rxd_cap - 13'h1) ? '0 : rxq_wr_ff + 12'h1;
    wire [11:0]  rxq_rd_n  = (13'(rxq_rd_ff) == rxd_cap - 13'h1) ? '0 : rxq_rd_ff + 12'h1;

    // fixed 128 byte receive staging buffer
    hfp_stage_fifo #(.DEPTH(RX_STG_WORDS), .AW(RX_STG_AW)) u_rx_stage (    // RQ15
        .clk_sys_in   (clk_sys_in),
        .reset_in     (reset_in),
        .flush_in     (flush),
        .push_in      (rstg_push),
        .push_data_in ({mac_rx_last_in, mac_rx_data_in}),
        .pop_in       (rx_drain),
        .head_out     (rstg_head),
        .count_out    (),
        .full_out     (rstg_full),
        .empty_out    (rstg_empty)
    );

    ////////////////////////////////////////////////////////////////////////////
    // shared buffer writes: tx data region and rx data region do not overlap for any size field except 0
    always_ff @(posedge clk_sys_in) begin
        if (txq_push) begin
            shared_mem[txq_wr_ff] <= {host_tx_last_in, host_tx_data_in};
        end
        if (rx_drain) begin
            shared_mem[12'(rx_base + rxq_wr_ff)] <= rstg_head;
        end
    end

    // queue pointers and levels
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || flush) begin                                 // RQ4
            txq_wr_ff  <= '0;
            txq_rd_ff  <= '0;
            txq_cnt_ff <= '0;
            rxq_wr_ff  <= '0;
            rxq_rd_ff  <= '0;
            rxq_cnt_ff <= '0;
        end else begin
            txq_wr_ff  <= txq_push ? txq_wr_n : txq_wr_ff;
            txq_rd_ff  <= tx_move ? txq_rd_n : txq_rd_ff;
            txq_cnt_ff <= txq_cnt_ff + 13'(txq_push) - 13'(tx_move);
            rxq_wr_ff  <= rx_drain ? rxq_wr_n : rxq_wr_ff;
            rxq_rd_ff  <= rxq_pop ? rxq_rd_n : rxq_rd_ff;
            rxq_cnt_ff <= rxq_cnt_ff + 13'(rx_drain) - 13'(rxq_pop);
        end
    end

    // frame tracking for staging and overrun
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || flush) begin
            tstg_frames_ff <= '0;
            rx_mid_ff      <= 1'b0;
            rx_lost_ff     <= 1'b0;
            discard_ff     <= 1'b0;
        end else begin
            tstg_frames_ff <= tstg_frames_ff + 2'(tx_move & txq_head[32])
                              - 2'(tx_out & tstg_head[32]);
            if (mac_rx_valid_in) begin
                rx_mid_ff  <= ~mac_rx_last_in;
                rx_lost_ff <= drop_now & ~mac_rx_last_in;            // RQ18
                discard_ff <= drop_now;
            end
        end
    end

    // dropped frame counter, one count per frame dropped from its first word
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || sr_done) begin
            drop_ff <= '0;
        end else if (drop_inc) begin
            drop_ff <= drop_ff + 32'h1;                              // RQ18
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // soft reset sequencer
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            sr_state_ff <= SR_IDLE;
            sr_cnt_ff   <= '0;
            sr_to_ff    <= 1'b0;
        end else begin
            unique case (sr_state_ff)
                SR_IDLE: begin
                    if (sr_req) begin                                // RQ3
                        sr_state_ff <= SR_BUSY;
                        sr_cnt_ff   <= SOFTWARE_RESET_REQUEST_CNT_INIT;
                        sr_to_ff    <= 1'b0;
                    end
                end
                SR_BUSY: begin
                    if (sr_abort) begin                              // RQ1
                        sr_state_ff <= SR_IDLE;
                        sr_to_ff    <= 1'b1;
                    end else if (sr_done) begin                      // RQ6
                        sr_state_ff <= SR_IDLE;
                    end else begin
                        sr_cnt_ff <= sr_cnt_ff - 3'h1;
                    end
                end
            endcase
        end
    end

    // system control and status bits; the exempt bit survives soft reset
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            txsz_ff      <= TXSZ_RST;
            exempt_ff    <= EXEMPT_RST;
            skip_ff      <= 1'b0;
            txe_ff       <= 1'b0;
            rxe_ff       <= 1'b0;
            read_seen_ff <= 1'b0;
        end else begin
            if (sr_done) begin
                txsz_ff <= TXSZ_RST;                                 // RQ4
            end else if (size_wr) begin
                txsz_ff   <= reg_wdata_in[TXSZ_LSB +: 4];
                exempt_ff <= reg_wdata_in[EXEMPT_BIT];
            end
            skip_ff      <= (wr_ok & sel_rxdp & reg_wdata_in[SKIP_BIT])
                            | (skip_ff & ~skip_end & ~sr_done);      // RQ20
            txe_ff       <= txe_set | (txe_ff & ~sr_done);           // RQ5
            rxe_ff       <= rxe_set | (rxe_ff & ~sr_done);           // RQ5
            read_seen_ff <= reg_rd_in | (read_seen_ff & ~sr_done);   // RQ8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            reg_rdata_out     <= '0;
            host_tx_full_out  <= 1'b0;
            host_rx_data_out  <= '0;
            host_rx_last_out  <= 1'b0;
            host_rx_valid_out <= 1'b0;
            mac_tx_data_out   <= '0;
            mac_tx_last_out   <= 1'b0;
            mac_tx_valid_out  <= 1'b0;
            mac_tx_avail_out  <= 1'b0;
            mac_csr_reset_out <= 1'b0;
        end else begin
            reg_rdata_out     <= reg_rd_in ? rd_mux : 32'h0;
            host_tx_full_out  <= txq_full;
            host_rx_data_out  <= host_pop ? rxq_head[31:0] : host_rx_data_out;
            host_rx_last_out  <= host_pop ? rxq_head[32] : host_rx_last_out;
            host_rx_valid_out <= host_pop;
            mac_tx_data_out   <= tx_out ? tstg_head[31:0] : mac_tx_data_out;
            mac_tx_last_out   <= tx_out ? tstg_head[32] : mac_tx_last_out;
            mac_tx_valid_out  <= tx_out;
            mac_tx_avail_out  <= ~tstg_empty & ~flush;
            mac_csr_reset_out <= sr_req | (sr_busy & ~sr_done & ~sr_abort); // RQ3
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    a_software_reset_request_timeout_set: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ1
        sr_abort |=> sr_to_ff && !sr_busy && $stable(txsz_ff))
        else $error("reset without phy clocks did not time out");
    a_software_reset_request_mac_reset: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ3
        sr_done |-> mac_csr_reset_out && $past(mac_csr_reset_out))
        else $error("mac register reset not held through soft reset");
    a_software_reset_request_system_control_status_regs_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ4
        sr_done |=> drop_ff == 32'h0 && rxq_cnt_ff == 13'h0 && txsz_ff == TXSZ_RST
                    && exempt_ff == $past(exempt_ff))
        else $error("system registers wrong after soft reset");
    a_software_reset_request_err_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ5
        sr_done && !txe_set && !rxe_set |=> !txe_ff && !rxe_ff)
        else $error("error flags survive soft reset");
    a_software_reset_request_self_clear: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ6
        sr_req && phy_clks_running_in [*1] ##1 phy_clks_running_in [*5]
        |=> !sr_busy)
        else $error("soft reset bit did not clear itself");
    a_write_first_read: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ8
        reg_wr_in && !read_seen_ff && !sr_done |=> $stable(txsz_ff) && !sr_busy)
        else $error("write took effect before first read");
    a_rx_split_sizes: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ11
        txsz_ff inside {[4'h2:4'he]} |-> rx_total + tx_total == BUF_WORDS
        && (rxs_cap << RXS_SHIFT) == rx_total && txd_cap + TXS_WORDS == tx_total)
        else $error("buffer partition inconsistent");
    a_rx_full_margin: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ14
        txsz_ff inside {[4'h2:4'he]} && !$past(size_wr) |-> rxq_cnt_ff <= rxd_lim)
        else $error("rx data queue passed its full mark");
    a_tx_stage_two: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ16
        tstg_frames_ff == TX_STG_FRAMES |-> !tx_move)
        else $error("tx staging took a third frame");
    a_drop_one_frame: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ18
        drop_inc && !sr_done |=> drop_ff == $past(drop_ff) + 32'h1)
        else $error("dropped frame count wrong");
    a_skip_complete: assert property (@(posedge clk_sys_in) disable iff (reset_in) // RQ20
        skip_end && !(wr_ok && sel_rxdp) |=> !skip_ff ##1 !host_rx_valid_out)
        else $error("skip flag did not clear at frame end");
    c_software_reset_request_timeout: cover property (@(posedge clk_sys_in) disable iff (reset_in) sr_abort);
    c_software_reset_request_done: cover property (@(posedge clk_sys_in) disable iff (reset_in) sr_done);
    c_rx_drop: cover property (@(posedge clk_sys_in) disable iff (reset_in) drop_inc);
    c_skip_end: cover property (@(posedge clk_sys_in) disable iff (reset_in) skip_end);
endmodule

// [shared/hfp_pkg.sv]
package hfp_pkg;
    // register byte offsets
    localparam logic [7:0]  HWCFG_OFS     = 8'h74; // hardware_configuration
    localparam logic [7:0]  RXDP_OFS      = 8'h78; // receive_datapath_control
    localparam logic [7:0]  DROP_OFS      = 8'ha0; // dropped frame counter
    localparam logic [7:0]  QSTAT_OFS     = 8'ha4; // error flags and rx data level
    localparam logic [7:0]  QSIZE_OFS     = 8'ha8; // data queue capacities
    localparam logic [7:0]  SSIZE_OFS     = 8'hac; // status queue capacities
    // field positions
    localparam int          SOFTWARE_RESET_REQUEST_BIT      = 0;
    localparam int          RESET_TIMEOUT_FLAG_BIT   = 1;
    localparam int          TXSZ_LSB      = 16;
    localparam int          EXEMPT_BIT    = 20;
    localparam int          SKIP_BIT      = 31;
    localparam int          TXE_BIT       = 30;
    localparam int          RXE_BIT       = 31;
    localparam int          RXS_LSB       = 8;
    localparam int          CAP_HI_LSB    = 16;
    // values after reset
    localparam logic [3:0]  TXSZ_RST      = 4'h5;
    localparam logic        EXEMPT_RST    = 1'b0;
    // buffer geometry, in 32-bit words
    localparam logic [12:0] BUF_WORDS     = 13'h1000; // 16384 bytes
    localparam int          KB_SHIFT      = 8;        // 1 KB = 256 words
    localparam logic [12:0] TXS_WORDS     = 13'h0080; // 512 bytes, 128 entries
    localparam int          RXS_SHIFT     = 4;        // status is 1/16 of rx
    localparam logic [12:0] RXD_MARGIN    = 13'h0004; // full 4 words early
    localparam int          TX_STG_WORDS  = 512;      // 2K bytes
    localparam int          TX_STG_AW     = 9;
    localparam int          RX_STG_WORDS  = 32;       // 128 bytes
    localparam int          RX_STG_AW     = 5;
    localparam logic [1:0]  TX_STG_FRAMES = 2'h2;
    // soft reset timing
    localparam int          CLK_NS        = 20;
    localparam int          SOFTWARE_RESET_REQUEST_NS       = 100;
    localparam int          SOFTWARE_RESET_REQUEST_CYC      = (SOFTWARE_RESET_REQUEST_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0]  SOFTWARE_RESET_REQUEST_CNT_INIT = 3'(SOFTWARE_RESET_REQUEST_CYC - 1);
    // soft reset sequencer
    typedef enum logic {SR_IDLE, SR_BUSY} hfp_sr_state_t;
endpackage
